//--- include/tcv_pkg.sv
// Constants, types and register map of one timer channel (mode control and value).
// Assumes a byte-wide register port and a counter that lives outside this channel.
package tcv_pkg;

  // Register offsets on the byte register port.
  localparam logic [1:0] TCV_OFS_CTRL = 2'h0;
  localparam logic [1:0] TCV_OFS_VAL_HI = 2'h1;
  localparam logic [1:0] TCV_OFS_VAL_LO = 2'h2;

  // Field positions in channel_control_status.
  localparam int TCV_BIT_FLAG = 7;
  localparam int TCV_BIT_IE = 6;
  localparam int TCV_BIT_MSHI = 5;
  localparam int TCV_BIT_MSLO = 4;
  localparam int TCV_BIT_ELHI = 3;
  localparam int TCV_BIT_ELLO = 2;

  // Reset values.
  localparam logic [15:0] TCV_VAL_RST = 16'h0000;
  localparam logic [7:0] TCV_BYTE_RST = 8'h00;

  // Edge/level codes.
  localparam logic [1:0] TCV_EL_OFF = 2'h0;
  localparam logic [1:0] TCV_EL_RISE_TOGGLE = 2'h1;
  localparam logic [1:0] TCV_EL_FALL_CLEAR = 2'h2;
  localparam logic [1:0] TCV_EL_BOTH_SET = 2'h3;

  // Clock selection code for a stopped counter.
  localparam logic [1:0] TCV_CLK_NONE = 2'h0;

  // Terminal count of a free-running counter, and the modulo value that selects it.
  localparam logic [15:0] TCV_FREE_TERM = 16'hffff;
  localparam logic [15:0] TCV_MOD_DISABLED = 16'h0000;

  // Channel modes, Gray coded along capture, compare, edge PWM, center PWM.
  typedef enum logic [1:0] {
    TCV_MODE_CAPTURE = 2'b00,
    TCV_MODE_COMPARE = 2'b01,
    TCV_MODE_EDGE_ALIGNED_PWM_MODE = 2'b11,
    TCV_MODE_CENTER_ALIGNED_PWM_MODE = 2'b10
  } tcv_mode_type;

  typedef struct packed {
    logic ie;
    logic ms_hi;
    logic ms_lo;
    logic [1:0] el;
    logic flag;
    logic clear_arm;
    logic [15:0] val;
    logic [15:0] wbuf;
    logic got_hi;
    logic got_lo;
    logic pend;
    logic [15:0] rbuf;
    logic rlatch;
    logic rfirst_hi;
    logic pin_prev;
    logic oc_out;
    logic pin_out;
    logic pin_oe;
    logic irq;
    logic [7:0] rdata;
  } tcv_state_type;

endpackage : tcv_pkg

//--- hw/tcv_channel.sv
// One timer channel: control fields, 16-bit value register with byte coherency,
// capture, compare and PWM pin logic.
// Assumes the shared counter, modulo, clock select and center-aligned select come
// from the timer core, and that counter_tick pulses in the cycle the count changes.
//
// Behaviour
// R1: Interrupt enable bit 6 gates requests; reset clears it.
// R2: Without center mode, mode_select_hi set gives edge-aligned PWM.
// R3: Otherwise mode_select_lo picks capture (0) or compare (1).
// R4: Edge/level 00 hands the pin back to general I/O.
// R5: Capture edges: 01 rising, 10 falling, 11 both.
// R6: Compare match: 01 toggle, 10 low, 11 high.
// R7: Edge PWM: 10 high-true pulses, bit0 set low-true pulses.
// R8: Center PWM: same polarity choice, any mode-select bits.
// R9: Value register holds capture or compare value; reset clears it.
// R10: Capture mode read latches both bytes until the other is read.
// R11: Control write releases the read latch, halted or not.
// R12: Value writes ignored in capture mode.
// R13: Debug halt freezes the read latch; only control write resets it.
// R14: Reads during debug halt return live value.
// R15: Compare/PWM writes go to a buffer until both bytes written.
// R16: Stopped counter: transfer on second byte write.
// R17: Compare mode with clock: transfer on next counter change.
// R18: PWM with clock: transfer when counter reaches modulo (or 0xFFFF).
// R19: Control write resets the write buffer latch.
// R20: Debug halt writes go straight to the value register.
// R21: Halt writes leave a partial buffered pair intact.
// R22: Pin must be stable two cycles before entering capture mode.
// R23: Interrupt request while flag set and enable is 1.
// R24: Center select forces center PWM for every channel.
// R25: Clock selection 00 stops the counter.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module tcv_channel
  import tcv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic debug_halt_mode,
  input wire logic center_aligned_select,
  input wire logic [1:0] clock_source_sel,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] counter_modulo,
  input wire logic counter_tick,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic channel_irq
);

  tcv_state_type st_r;
  tcv_state_type st_nxt;
  tcv_mode_type mode;
  logic [15:0] term;
  logic [15:0] wnew;
  logic match;
  logic rise;
  logic fall;
  logic cap_evt;
  logic cmp_evt;
  logic pwm;
  logic clk_on;
  logic pwm_level;

  function automatic tcv_mode_type tcv_mode_decode(input logic ctr, input logic mhi,
                                                   input logic mlo);
    tcv_mode_type m;
    if (ctr)
      m = TCV_MODE_CENTER_ALIGNED_PWM_MODE;
    else if (mhi)
      m = TCV_MODE_EDGE_ALIGNED_PWM_MODE;
    else if (mlo)
      m = TCV_MODE_COMPARE;
    else
      m = TCV_MODE_CAPTURE;
    return m;
  endfunction : tcv_mode_decode

  always_comb
  begin
    st_nxt = st_r;
    // R24 mode decode
    // R2 edge PWM select
    // R3 capture or compare
    mode = tcv_mode_decode(center_aligned_select, st_r.ms_hi, st_r.ms_lo);
    pwm = (mode == TCV_MODE_EDGE_ALIGNED_PWM_MODE) || (mode == TCV_MODE_CENTER_ALIGNED_PWM_MODE);
    // R25 stopped counter
    clk_on = (clock_source_sel != TCV_CLK_NONE);
    term = (counter_modulo == TCV_MOD_DISABLED) ? TCV_FREE_TERM : counter_modulo;
    match = counter_tick && (counter_value == st_r.val);
    rise = pin_in && !st_r.pin_prev;
    fall = !pin_in && st_r.pin_prev;
    wnew = st_r.wbuf;
    if (reg_addr == TCV_OFS_VAL_HI)
      wnew[15:8] = reg_wdata;
    else
      wnew[7:0] = reg_wdata;
    // R5 capture edge select
    cap_evt = 1'b0;
    if (mode == TCV_MODE_CAPTURE)
    begin
      case (st_r.el)
        TCV_EL_RISE_TOGGLE: cap_evt = rise;
        TCV_EL_FALL_CLEAR: cap_evt = fall;
        TCV_EL_BOTH_SET: cap_evt = rise || fall;
        default: cap_evt = 1'b0;
      endcase
    end
    // A 0% or 100% duty cycle raises no flag.
    cmp_evt = (mode != TCV_MODE_CAPTURE) && match &&
              !(pwm && ((st_r.val == TCV_VAL_RST) || (st_r.val > term)));
    // R7 edge PWM polarity
    // R8 center PWM polarity
    pwm_level = (counter_value < st_r.val);
    if (st_r.el[0])
      pwm_level = !pwm_level;

    st_nxt.pin_prev = pin_in;
    st_nxt.rdata = TCV_BYTE_RST;

    // R9 capture into value
    if (cap_evt)
      st_nxt.val = counter_value;

    // R6 compare pin action
    if (mode == TCV_MODE_COMPARE && match)
    begin
      case (st_r.el)
        TCV_EL_RISE_TOGGLE: st_nxt.oc_out = !st_r.oc_out;
        TCV_EL_FALL_CLEAR: st_nxt.oc_out = 1'b0;
        TCV_EL_BOTH_SET: st_nxt.oc_out = 1'b1;
        default: st_nxt.oc_out = st_r.oc_out;
      endcase
    end

    // R17 compare transfer
    // R18 PWM transfer
    if (st_r.pend && !debug_halt_mode &&
        (!clk_on || (mode == TCV_MODE_COMPARE && counter_tick) ||
         (pwm && counter_tick && counter_value == term)))
    begin
      st_nxt.val = st_r.wbuf;
      st_nxt.pend = 1'b0;
    end

    if (reg_wr)
    begin
      case (reg_addr)
        TCV_OFS_CTRL:
        begin
          // R1 enable write
          st_nxt.ie = reg_wdata[TCV_BIT_IE];
          st_nxt.ms_hi = reg_wdata[TCV_BIT_MSHI];
          st_nxt.ms_lo = reg_wdata[TCV_BIT_MSLO];
          st_nxt.el = reg_wdata[TCV_BIT_ELHI:TCV_BIT_ELLO];
          // Flag clears only after a read that saw it set.
          if (st_r.clear_arm && !reg_wdata[TCV_BIT_FLAG])
            st_nxt.flag = 1'b0;
          st_nxt.clear_arm = 1'b0;
          // R11 release read latch
          st_nxt.rlatch = 1'b0;
          // R19 reset write latch
          st_nxt.got_hi = 1'b0;
          st_nxt.got_lo = 1'b0;
          st_nxt.pend = 1'b0;
        end
        TCV_OFS_VAL_HI, TCV_OFS_VAL_LO:
        begin
          // R12 capture ignores writes
          if (mode == TCV_MODE_CAPTURE)
            st_nxt.val = st_nxt.val;
          // R20 halt direct write
          // R21 partial pair kept
          else if (debug_halt_mode)
          begin
            if (reg_addr == TCV_OFS_VAL_HI)
              st_nxt.val[15:8] = reg_wdata;
            else
              st_nxt.val[7:0] = reg_wdata;
          end
          // R15 buffered pair write
          else
          begin
            st_nxt.wbuf = wnew;
            st_nxt.got_hi = st_r.got_hi || (reg_addr == TCV_OFS_VAL_HI);
            st_nxt.got_lo = st_r.got_lo || (reg_addr == TCV_OFS_VAL_LO);
            if (st_nxt.got_hi && st_nxt.got_lo)
            begin
              st_nxt.got_hi = 1'b0;
              st_nxt.got_lo = 1'b0;
              // R16 stopped counter transfer
              if (!clk_on)
                st_nxt.val = wnew;
              else
                st_nxt.pend = 1'b1;
            end
          end
        end
        default:
        begin
          st_nxt.clear_arm = st_r.clear_arm;
        end
      endcase
    end

    if (reg_rd)
    begin
      case (reg_addr)
        TCV_OFS_CTRL:
        begin
          st_nxt.rdata = {st_r.flag, st_r.ie, st_r.ms_hi, st_r.ms_lo, st_r.el, 2'b00};
          if (st_r.flag)
            st_nxt.clear_arm = 1'b1;
        end
        TCV_OFS_VAL_HI, TCV_OFS_VAL_LO:
        begin
          // R14 halt reads live
          // R13 halt freezes latch
          if (mode != TCV_MODE_CAPTURE || debug_halt_mode)
            st_nxt.rdata = (reg_addr == TCV_OFS_VAL_HI) ? st_r.val[15:8] : st_r.val[7:0];
          // R10 coherent capture read
          else if (!st_r.rlatch)
          begin
            st_nxt.rbuf = st_r.val;
            st_nxt.rlatch = 1'b1;
            st_nxt.rfirst_hi = (reg_addr == TCV_OFS_VAL_HI);
            st_nxt.rdata = (reg_addr == TCV_OFS_VAL_HI) ? st_r.val[15:8] : st_r.val[7:0];
          end
          else
          begin
            st_nxt.rdata = (reg_addr == TCV_OFS_VAL_HI) ? st_r.rbuf[15:8] : st_r.rbuf[7:0];
            if (st_r.rfirst_hi != (reg_addr == TCV_OFS_VAL_HI))
              st_nxt.rlatch = 1'b0;
          end
        end
        default:
        begin
          st_nxt.rdata = TCV_BYTE_RST;
        end
      endcase
    end

    // An event in the clearing cycle wins over the clear.
    if (cap_evt || cmp_evt)
      st_nxt.flag = 1'b1;

    // R4 pin released
    st_nxt.pin_oe = (st_r.el != TCV_EL_OFF) && (mode != TCV_MODE_CAPTURE);
    if (mode == TCV_MODE_COMPARE)
      st_nxt.pin_out = st_nxt.oc_out;
    else if (pwm)
      st_nxt.pin_out = pwm_level;
    else
      st_nxt.pin_out = 1'b0;
    // R23 interrupt request
    st_nxt.irq = st_nxt.flag && st_nxt.ie;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.val <= TCV_VAL_RST;
    end
    else
      st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign pin_out = st_r.pin_out;
  assign pin_oe = st_r.pin_oe;
  assign channel_irq = st_r.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_IRQ_GATED: assert property (channel_irq |-> st_r.ie && st_r.flag) // R1
    else $error("irq without enable and flag");
  AST_IRQ_RAISED: assert property (st_r.flag && st_r.ie |-> channel_irq) // R23
    else $error("irq missing while flag and enable set");
  AST_PIN_RELEASED: assert property (st_r.el == TCV_EL_OFF |=> !pin_oe) // R4
    else $error("pin driven with edge/level off");
  AST_EDGE_ALIGNED_PWM_MODE_SEL: assert property (!center_aligned_select && st_r.ms_hi |-> mode == TCV_MODE_EDGE_ALIGNED_PWM_MODE) // R2
    else $error("edge PWM not selected");
  AST_CAP_IGNORE_WR: assert property (mode == TCV_MODE_CAPTURE && reg_wr &&
    reg_addr != TCV_OFS_CTRL && !cap_evt |=> st_r.val == $past(st_r.val)) // R12
    else $error("value changed by write in capture mode");
  AST_CTRL_RELEASE: assert property (reg_wr && reg_addr == TCV_OFS_CTRL
    |=> !st_r.rlatch && !st_r.got_hi && !st_r.got_lo) // R11
    else $error("control write left a latch set");
  AST_HALT_FREEZE: assert property (debug_halt_mode && !(reg_wr && reg_addr == TCV_OFS_CTRL)
    |=> st_r.rlatch == $past(st_r.rlatch)) // R13
    else $error("read latch moved during halt");
  AST_STOP_XFER: assert property (reg_wr && !debug_halt_mode &&
    (reg_addr == TCV_OFS_VAL_HI || reg_addr == TCV_OFS_VAL_LO) &&
    mode != TCV_MODE_CAPTURE && !clk_on && (st_r.got_hi || st_r.got_lo) &&
    (st_r.got_hi != (reg_addr == TCV_OFS_VAL_HI)) |=> st_r.val == $past(wnew)) // R16
    else $error("stopped-counter transfer missed");
  AST_CAPTURE: assert property (cap_evt |=> st_r.val == $past(counter_value) ##0 st_r.flag) // R5
    else $error("capture did not load count");
  AST_OC_SET: assert property (mode == TCV_MODE_COMPARE && match && st_r.el == TCV_EL_BOTH_SET
    |=> ##1 pin_out) // R6
    else $error("compare set did not drive high");

  COV_CAPTURE: cover property (cap_evt ##1 reg_rd && reg_addr == TCV_OFS_VAL_HI);
  COV_PAIR_PEND: cover property (st_r.pend ##[1:20] !st_r.pend);
  COV_HALT_WR: cover property (debug_halt_mode && reg_wr && reg_addr == TCV_OFS_VAL_LO);
  COV_PWM: cover property (pwm && pin_oe && pin_out);

endmodule : tcv_channel

`default_nettype wire

//--- verification/tcv_pin_model.sv
// Model of the signal source that drives the channel pin.
// Assumes the bench asks for a level and the pin follows it at the next clock edge.
`timescale 1ns/1ps
`default_nettype none
module tcv_pin_model (
  input wire logic ref_clk,
  input wire logic want_level,
  output logic pin_level
);
  initial pin_level = 1'b0;
  // stable before capture
  // The level only moves on request, so it has long settled whenever the mode changes.
  always @(posedge ref_clk)
  begin
    pin_level <= want_level;
  end
endmodule : tcv_pin_model
`default_nettype wire

//--- verification/timer_channel_mode_and_value_tb.sv
// Self-checking bench of one timer channel: registers, capture, compare and PWM.
// Assumes tcv_pkg, the channel module and the pin model; the bench plays the counter.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_and_value_tb;
  import tcv_pkg::*;
  logic ref_clk, sys_rst, reg_wr, reg_rd, halt, cas, tick, pin, want, pin_out, pin_oe, irq;
  logic [1:0] addr, csel;
  logic [7:0] wdata, rdata, b;
  logic [15:0] cnt, seed, rv16, modv;
  logic [7:0] pwm_ctrl [3] = '{8'h28, 8'h24, 8'h08};
  int num_errors = 0;
  int compares = 0;
  tcv_channel dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .debug_halt_mode(halt),
    .center_aligned_select(cas), .clock_source_sel(csel), .counter_value(cnt),
    .counter_modulo(modv), .counter_tick(tick), .pin_in(pin),
    .pin_out(pin_out), .pin_oe(pin_oe), .channel_irq(irq));
  tcv_pin_model pm (.ref_clk(ref_clk), .want_level(want), .pin_level(pin));
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand
  // PWM level: high while the count is below the value, inverted for low-true pulses.
  function automatic logic pwm_level(input logic [15:0] c, input logic [15:0] v, input logic lo);
    return (c < v) ^ lo;
  endfunction : pwm_level
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : step
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task automatic rv(output logic [15:0] r);
    rd(TCV_OFS_VAL_HI, r[15:8]);
    rd(TCV_OFS_VAL_LO, r[7:0]);
  endtask : rv
  task automatic wv(input logic [15:0] v);
    wr(TCV_OFS_VAL_HI, v[15:8]);
    wr(TCV_OFS_VAL_LO, v[7:0]);
  endtask : wv
  task automatic pulse(input logic [15:0] c);
    @(posedge ref_clk);
    cnt <= c;
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
  endtask : pulse
  // The pin driven low, then high for a rising edge, with the counter showing c.
  task automatic edge_at(input logic [15:0] c);
    cnt <= c;
    want <= 1'b0;
    step(3);
    want <= 1'b1;
    step(4);
  endtask : edge_at
  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #50000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    {sys_rst, reg_wr, reg_rd, halt, cas, tick, want} = 7'b1000000;
    {addr, csel, wdata, cnt} = '0;
    modv = TCV_MOD_DISABLED;
    seed = 16'h0606;
    step(16);
    sys_rst <= 1'b0;
    for (int a = 0; a < 4; a++)
    begin
      rd(a[1:0], b);
      check("reset byte", 16'h0000, {8'h00, b});
    end
    wr(TCV_OFS_CTRL, 8'h44);
    seed = next_rand(seed);
    edge_at(seed);
    check("irq", 16'h0001, {15'h0, irq});
    wr(TCV_OFS_VAL_HI, 8'hff);
    rv(rv16);
    check("capture", seed, rv16);
    cnt <= ~seed;
    want <= 1'b0;
    step(4);
    rv(rv16);
    check("falling ignored", seed, rv16);
    rd(TCV_OFS_VAL_HI, b);
    edge_at(seed ^ 16'h5a5a);
    halt <= 1'b1;
    rd(TCV_OFS_VAL_LO, b);
    check("halt live read", {8'h00, seed[7:0] ^ 8'h5a}, {8'h00, b});
    halt <= 1'b0;
    rd(TCV_OFS_VAL_LO, b);
    check("latched low", {8'h00, seed[7:0]}, {8'h00, b});
    rd(TCV_OFS_VAL_HI, b);
    edge_at(16'h0c3e);
    wr(TCV_OFS_CTRL, 8'h44);
    rd(TCV_OFS_VAL_LO, b);
    check("latch released", 16'h003e, {8'h00, b});
    wr(TCV_OFS_CTRL, 8'h1c);
    step(2);
    check("compare drives pin", 16'h0001, {15'h0, pin_oe});
    seed = next_rand(seed);
    wv(seed);
    rv(rv16);
    check("stopped transfer", seed, rv16);
    wr(TCV_OFS_VAL_HI, 8'h12);
    wr(TCV_OFS_CTRL, 8'h1c);
    wr(TCV_OFS_VAL_LO, 8'h34);
    rv(rv16);
    check("half pair", seed, rv16);
    wr(TCV_OFS_VAL_HI, 8'h56);
    rv(rv16);
    check("pair after reset", 16'h5634, rv16);
    csel <= 2'h1;
    wv(16'habcd);
    rv(rv16);
    check("wait for tick", 16'h5634, rv16);
    pulse(16'h0001);
    rv(rv16);
    check("tick transfer", 16'habcd, rv16);
    wr(TCV_OFS_VAL_HI, 8'h11);
    halt <= 1'b1;
    wr(TCV_OFS_VAL_LO, 8'h22);
    rv(rv16);
    check("halt direct write", 16'habcd ^ 16'h00ef, rv16);
    halt <= 1'b0;
    wr(TCV_OFS_VAL_LO, 8'h33);
    pulse(16'h0002);
    rv(rv16);
    check("pair kept over halt", 16'h1133, rv16);
    for (int el = 3; el > 0; el--)
    begin
      wr(TCV_OFS_CTRL, {4'h1, el[1:0], 2'b00});
      pulse(16'h1133);
      step(3);
      check("compare pin", {15'h0, el != 2}, {15'h0, pin_out});
    end
    wr(TCV_OFS_CTRL, 8'h10);
    step(2);
    check("pin released", 16'h0000, {15'h0, pin_oe});
    for (int k = 0; k < 3; k++)
    begin
      cas <= (k == 2);
      wr(TCV_OFS_CTRL, pwm_ctrl[k]);
      for (int i = 0; i < 4; i++)
      begin
        seed = next_rand(seed);
        cnt <= (i == 0) ? 16'h1133 : seed;
        step(3);
        check("pwm pin", {15'h0, pwm_level(cnt, 16'h1133, pwm_ctrl[k][2])}, {15'h0, pin_out});
      end
    end
    cas <= 1'b0;
    wr(TCV_OFS_CTRL, 8'h28);
    wv(16'h0200);
    pulse(16'hfffe);
    rv(rv16);
    check("pwm before terminal", 16'h1133, rv16);
    pulse(16'hffff);
    rv(rv16);
    check("pwm at terminal", 16'h0200, rv16);
    // A modulo limit moves the PWM transfer point to the modulo count.
    modv <= 16'h0300;
    wv(16'h0100);
    pulse(16'h02ff);
    rv(rv16);
    check("pwm before modulo", 16'h0200, rv16);
    pulse(16'h0300);
    rv(rv16);
    check("pwm at modulo", 16'h0100, rv16);
    // The pin has stood high for many cycles, so entering capture sees no false edge.
    wr(TCV_OFS_CTRL, 8'h08);
    seed = next_rand(seed);
    cnt <= seed;
    want <= 1'b0;
    step(4);
    rv(rv16);
    check("falling capture", seed, rv16);
    wr(TCV_OFS_CTRL, 8'h0c);
    seed = next_rand(seed);
    cnt <= seed;
    want <= 1'b1;
    step(4);
    rv(rv16);
    check("either edge capture", seed, rv16);
    report_and_stop();
  end
endmodule : timer_channel_mode_and_value_tb
`default_nettype wire
